// file: verilog/adc_ctrl_regs.svh
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define REG_GEN_CFG 8'h00
`define REG_SYS_STATUS 8'h04
`define REG_AVG_CFG 8'h08
`define REG_TIMING_CFG 8'h0C
`define REG_PIN_CFG 8'h10
`define REG_DIR_CFG 8'h14
`define REG_DRIVE_CFG 8'h18
`define REG_OUT_LEVELS 8'h1C
`define REG_IN_LEVELS 8'h20
`define REG_SEQ_SEL 8'h24
`define REG_MANUAL_CH 8'h28
`define REG_EVENT_FLAGS 8'h2C
`define REG_THRESH_HIGH 8'h30
`define REG_THRESH_LOW 8'h34
`define REG_RESULT_BASE 8'h40
`define REG_RESULT_LAST 8'h7C

// ****************************************
// field positions
// ****************************************
`define GEN_CRC_EN 0
`define GEN_STATISTICS_ENABLE 1
`define GEN_CONVERSION_START_BIT 2
`define GEN_ALERT_CRC 3
`define GEN_APPEND_LO 4
`define GEN_APPEND_HI 5
`define GEN_STOP_ERR 6
`define GEN_AUTO 7
`define STAT_CRC_ERR 0
`define STAT_AVG_DONE 1
`define STAT_BUSY 2
`define STAT_SCL 3
`define TIM_DIV_HI 3
`define TIM_OSCILLATOR_SELECT 4

// ****************************************
// values and timing
// ****************************************
`define GEN_CFG_RST 8'h00
`define AVG_CFG_RST 3'h0
`define TIMING_RST 5'h00
`define THRESH_HIGH_RST 12'hFFF
`define THRESH_LOW_RST 12'h000
`define APPEND_FLAGS 2'h2
`define FLAGS_FIXED 2'h2
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define RESULT_FRAC 4
`define OSC1_SHIFT 5
`define CLK_PERIOD_NS 20
`define CYCLE_UNIT_NS 500

`endif

// file: verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_CONV = 2'b01,
    S_SPACE = 2'b10
  } seq_state_e;
endpackage : adc_ctrl_pkg

// file: verilog/adc_avg_crc_gpio_timing_ctrl.sv
// Contract
// - one oversample setting for all channels
// - averaged result is sixteen bits wide
// - host starts first conversion, rest internal
// - bus-started averaging holds SCL low throughout
// - register start averages without any stretching
// - averaging done bit readable in status
// - result lands in latest low/high registers
// - autonomous mode walks enabled channels in turn
// - comparator uses top twelve result bits
// - check byte sent and checked per byte
// - check polynomial x8+x2+x+1
// - bad incoming byte dropped, error flag set
// - error flag blocks writes, write-one clears
// - alert output on check error when enabled
// - append select 10 adds four flags
// - autonomous conversions halt on check error
// - per-channel analog, input, output drive modes
// - outputs follow levels, inputs readable
// - internal spacing from oscillator and divider
// - conversion time independent of spacing setting
// - flags are one, zero, error, event-or
//
// Design decisions made here: the register offsets and strobed register access.
`include "adc_ctrl_regs.svh"

module adc_avg_crc_gpio_timing_ctrl #(
  parameter int CHANNELS = 8,
  parameter int UNIT_CYCLES = `CYCLE_UNIT_NS / `CLK_PERIOD_NS,
  parameter int TIMER_W = 20
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic [7:0] rx_crc_in,
  output logic rx_valid_out,
  output logic [7:0] rx_byte_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_byte_in,
  output logic tx_crc_valid_out,
  output logic [7:0] tx_crc_out,
  input wire logic bus_conv_req_in,
  output logic result_valid_out,
  output logic [19:0] result_frame_out,
  input wire logic scl_in,
  output logic scl_out_out,
  output logic scl_oe_out,
  output logic adc_start_out,
  output logic [2:0] adc_ch_out,
  input wire logic adc_done_in,
  input wire logic [11:0] adc_data_in,
  input wire logic [7:0] gpio_in_in,
  output logic [7:0] gpio_out_out,
  output logic [7:0] gpio_oe_out,
  output logic alert_out
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] crc8(input logic [7:0] data);
    logic [7:0] c;
    c = `CRC_INIT;
    for (int i = 7; i >= 0; i--) begin
      c = (c[7] ^ data[i]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

  // cycle time in half-microsecond units for divider codes
  function automatic logic [8:0] div_mult(input logic [3:0] d);
    logic [8:0] base;
    base = d[0] ? 9'h003 : 9'h002;
    return 9'(base << d[3:1]);
  endfunction : div_mult

  function automatic logic [2:0] next_ch(input logic [2:0] cur, input logic [7:0] mask);
    logic [2:0] n;
    logic found;
    n = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      if (!found && mask[3'(cur + 3'(i))]) begin
        n = 3'(cur + 3'(i));
        found = 1'b1;
      end
    end
    return n;
  endfunction : next_ch

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] gen_cfg_r;
  logic [2:0] avg_cfg_r;
  logic [4:0] timing_r;
  logic [7:0] pin_cfg_r, dir_cfg_r, drive_cfg_r, out_levels_r, seq_sel_r, event_flags_r;
  logic [2:0] manual_ch_r;
  logic [11:0] thresh_high_r, thresh_low_r;
  logic crc_err_r, avg_done_r, stretch_r;
  logic [15:0] result_mem [CHANNELS];
  logic [1:0] scl_sync_r;
  logic [7:0] gpi_meta_r, gpi_sync_r;
  adc_ctrl_pkg::seq_state_e state_r;
  logic [2:0] ch_r;
  logic [7:0] cnt_r;
  logic [18:0] acc_r;
  logic [TIMER_W-1:0] timer_r, spacing_r;

  wire logic crc_en = gen_cfg_r[`GEN_CRC_EN];
  wire logic auto_mode = gen_cfg_r[`GEN_AUTO];
  wire logic [1:0] append_sel = gen_cfg_r[`GEN_APPEND_HI:`GEN_APPEND_LO];
  wire logic wr_ok = wr_in && !crc_err_r;
  wire logic conversion_start_bit_wr = wr_ok && addr_in == `REG_GEN_CFG && wdata_in[`GEN_CONVERSION_START_BIT];
  wire logic halt = auto_mode && gen_cfg_r[`GEN_STOP_ERR] && crc_err_r;
  wire logic rx_bad = rx_valid_in && crc_en && crc8(rx_byte_in) != rx_crc_in;
  wire logic [7:0] input_levels = gpi_sync_r & pin_cfg_r & ~dir_cfg_r;
  wire logic [7:0] samples_m1 = 8'((9'h001 << avg_cfg_r) - 9'h001);

  // ****************************************
  // configuration writes
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gen_cfg_r <= `GEN_CFG_RST;
      avg_cfg_r <= `AVG_CFG_RST;
      timing_r <= `TIMING_RST;
      pin_cfg_r <= 8'h00;
      dir_cfg_r <= 8'h00;
      drive_cfg_r <= 8'h00;
      out_levels_r <= 8'h00;
      seq_sel_r <= 8'h00;
      manual_ch_r <= 3'h0;
      thresh_high_r <= `THRESH_HIGH_RST;
      thresh_low_r <= `THRESH_LOW_RST;
    end else if (wr_ok) begin
      if (addr_in == `REG_GEN_CFG) begin
        gen_cfg_r <= wdata_in[7:0] & ~(8'h01 << `GEN_CONVERSION_START_BIT);
      end else if (addr_in == `REG_AVG_CFG) begin
        avg_cfg_r <= wdata_in[2:0];
      end else if (addr_in == `REG_TIMING_CFG) begin
        timing_r <= wdata_in[4:0];
      end else if (addr_in == `REG_PIN_CFG) begin
        pin_cfg_r <= wdata_in[7:0];
      end else if (addr_in == `REG_DIR_CFG) begin
        dir_cfg_r <= wdata_in[7:0];
      end else if (addr_in == `REG_DRIVE_CFG) begin
        drive_cfg_r <= wdata_in[7:0];
      end else if (addr_in == `REG_OUT_LEVELS) begin
        out_levels_r <= wdata_in[7:0];
      end else if (addr_in == `REG_SEQ_SEL) begin
        seq_sel_r <= wdata_in[7:0];
      end else if (addr_in == `REG_MANUAL_CH) begin
        manual_ch_r <= wdata_in[2:0];
      end else if (addr_in == `REG_THRESH_HIGH) begin
        thresh_high_r <= wdata_in[11:0];
      end else if (addr_in == `REG_THRESH_LOW) begin
        thresh_low_r <= wdata_in[11:0];
      end
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_sync_r <= 2'b11;
      gpi_meta_r <= 8'h00;
      gpi_sync_r <= 8'h00;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      gpi_meta_r <= gpio_in_in;
      gpi_sync_r <= gpi_meta_r;
    end
  end

  // ****************************************
  // check bytes on the serial link
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_valid_out <= 1'b0;
      rx_byte_out <= 8'h00;
      tx_crc_valid_out <= 1'b0;
      tx_crc_out <= 8'h00;
    end else begin
      rx_valid_out <= rx_valid_in && !rx_bad;
      if (rx_valid_in && !rx_bad) begin
        rx_byte_out <= rx_byte_in;
      end
      tx_crc_valid_out <= tx_valid_in && crc_en;
      if (tx_valid_in) begin
        tx_crc_out <= crc8(tx_byte_in);
      end
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  logic [18:0] sum_nxt;
  logic [15:0] avg_nxt;
  logic [TIMER_W-1:0] cycle_cnt;
  logic last_sample, done_evt, idle_start;
  logic [2:0] start_ch;

  always_comb begin
    sum_nxt = acc_r + 19'(adc_data_in);
    avg_nxt = 16'((23'(sum_nxt) << `RESULT_FRAC) >> avg_cfg_r);
    cycle_cnt = TIMER_W'(div_mult(timing_r[`TIM_DIV_HI:0]) * UNIT_CYCLES) <<
      (timing_r[`TIM_OSCILLATOR_SELECT] ? `OSC1_SHIFT : 0);
    last_sample = state_r == adc_ctrl_pkg::S_CONV && adc_done_in && cnt_r == samples_m1;
    done_evt = last_sample;
    idle_start = state_r == adc_ctrl_pkg::S_IDLE &&
      (bus_conv_req_in || conversion_start_bit_wr || (auto_mode && !halt && seq_sel_r != 8'h00));
    start_ch = auto_mode ? next_ch(3'h7, seq_sel_r) : manual_ch_r;
  end

  // conversion length belongs to the converter; only the gap is timed here
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= adc_ctrl_pkg::S_IDLE;
      ch_r <= 3'h0;
      cnt_r <= 8'h00;
      acc_r <= 19'h0;
      timer_r <= '0;
      spacing_r <= '0;
      adc_start_out <= 1'b0;
    end else begin
      adc_start_out <= 1'b0;
      if (timer_r != '0) begin
        timer_r <= timer_r - 1'b1;
      end
      case (state_r)
        adc_ctrl_pkg::S_IDLE: begin
          if (idle_start) begin
            ch_r <= start_ch;
            cnt_r <= 8'h00;
            acc_r <= 19'h0;
            timer_r <= cycle_cnt;
            spacing_r <= cycle_cnt;
            adc_start_out <= 1'b1;
            state_r <= adc_ctrl_pkg::S_CONV;
          end
        end
        adc_ctrl_pkg::S_CONV: begin
          if (adc_done_in) begin
            if (last_sample) begin
              acc_r <= 19'h0;
              cnt_r <= 8'h00;
              ch_r <= next_ch(ch_r, seq_sel_r);
              state_r <= (auto_mode && !halt && seq_sel_r != 8'h00) ? adc_ctrl_pkg::S_SPACE : adc_ctrl_pkg::S_IDLE;
            end else begin
              acc_r <= sum_nxt;
              cnt_r <= cnt_r + 8'h01;
              state_r <= adc_ctrl_pkg::S_SPACE;
            end
          end
        end
        adc_ctrl_pkg::S_SPACE: begin
          if (halt) begin
            state_r <= adc_ctrl_pkg::S_IDLE;
          end else if (timer_r <= TIMER_W'(1)) begin
            timer_r <= cycle_cnt;
            spacing_r <= cycle_cnt;
            adc_start_out <= 1'b1;
            state_r <= adc_ctrl_pkg::S_CONV;
          end
        end
        default: begin
          state_r <= adc_ctrl_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign adc_ch_out = ch_r;

  // ****************************************
  // results, flags, stretching
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (done_evt) begin
      result_mem[ch_r] <= avg_nxt;
    end
  end

  wire logic w1c_status = wr_in && addr_in == `REG_SYS_STATUS;
  wire logic w1c_events = wr_ok && addr_in == `REG_EVENT_FLAGS;
  wire logic out_of_window = avg_nxt[15:4] > thresh_high_r || avg_nxt[15:4] < thresh_low_r;
  wire logic [3:0] status_flags = {`FLAGS_FIXED, crc_err_r, |event_flags_r};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      crc_err_r <= 1'b0;
      avg_done_r <= 1'b0;
      event_flags_r <= 8'h00;
    end else begin
      crc_err_r <= rx_bad || (crc_err_r && !(w1c_status && wdata_in[`STAT_CRC_ERR]));
      avg_done_r <= done_evt || (avg_done_r && !(w1c_status && wdata_in[`STAT_AVG_DONE]));
      event_flags_r <= (event_flags_r & ~(w1c_events ? wdata_in[7:0] : 8'h00)) |
        ((done_evt && out_of_window) ? (8'h01 << ch_r) : 8'h00);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      stretch_r <= 1'b0;
      result_valid_out <= 1'b0;
      result_frame_out <= 20'h0;
      alert_out <= 1'b0;
    end else begin
      if (state_r == adc_ctrl_pkg::S_IDLE && bus_conv_req_in) begin
        stretch_r <= 1'b1;
      end else if (done_evt) begin
        stretch_r <= 1'b0;
      end
      result_valid_out <= done_evt;
      if (done_evt) begin
        result_frame_out <= {avg_nxt, (append_sel == `APPEND_FLAGS) ? status_flags : 4'h0};
      end
      alert_out <= (gen_cfg_r[`GEN_ALERT_CRC] && crc_err_r) || (|event_flags_r);
    end
  end

  // register starts never stretch the clock
  assign scl_oe_out = stretch_r;
  assign scl_out_out = 1'b0;

  // ****************************************
  // channel pins
  // ****************************************
  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_pin
      wire logic is_out = pin_cfg_r[i] && dir_cfg_r[i];
      // open-drain drives only the low level
      assign gpio_out_out[i] = drive_cfg_r[i] ? out_levels_r[i] : 1'b0;
      assign gpio_oe_out[i] = is_out && (drive_cfg_r[i] || !out_levels_r[i]);
    end
  endgenerate

  // ****************************************
  // register reads
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0;
    end else if (rd_in) begin
      if (addr_in == `REG_GEN_CFG) begin
        rdata_out <= {24'h0, gen_cfg_r};
      end else if (addr_in == `REG_SYS_STATUS) begin
        rdata_out <= {28'h0, scl_sync_r[1], state_r != adc_ctrl_pkg::S_IDLE, avg_done_r, crc_err_r};
      end else if (addr_in == `REG_AVG_CFG) begin
        rdata_out <= {29'h0, avg_cfg_r};
      end else if (addr_in == `REG_TIMING_CFG) begin
        rdata_out <= {27'h0, timing_r};
      end else if (addr_in == `REG_PIN_CFG) begin
        rdata_out <= {24'h0, pin_cfg_r};
      end else if (addr_in == `REG_DIR_CFG) begin
        rdata_out <= {24'h0, dir_cfg_r};
      end else if (addr_in == `REG_DRIVE_CFG) begin
        rdata_out <= {24'h0, drive_cfg_r};
      end else if (addr_in == `REG_OUT_LEVELS) begin
        rdata_out <= {24'h0, out_levels_r};
      end else if (addr_in == `REG_IN_LEVELS) begin
        rdata_out <= {24'h0, input_levels};
      end else if (addr_in == `REG_SEQ_SEL) begin
        rdata_out <= {24'h0, seq_sel_r};
      end else if (addr_in == `REG_MANUAL_CH) begin
        rdata_out <= {29'h0, manual_ch_r};
      end else if (addr_in == `REG_EVENT_FLAGS) begin
        rdata_out <= {24'h0, event_flags_r};
      end else if (addr_in == `REG_THRESH_HIGH) begin
        rdata_out <= {20'h0, thresh_high_r};
      end else if (addr_in == `REG_THRESH_LOW) begin
        rdata_out <= {20'h0, thresh_low_r};
      end else if (addr_in >= `REG_RESULT_BASE && addr_in <= `REG_RESULT_LAST && addr_in[1:0] == 2'h0) begin
        rdata_out <= {24'h0, addr_in[2] ? result_mem[addr_in[5:3]][15:8] : result_mem[addr_in[5:3]][7:0]};
      end else begin
        rdata_out <= 32'h0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  logic [TIMER_W-1:0] gap_r;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r <= '0;
    end else if (adc_start_out) begin
      gap_r <= '0;
    end else if (gap_r != '1) begin
      gap_r <= gap_r + 1'b1;
    end
  end

  sequence s_bus_start;
    state_r == adc_ctrl_pkg::S_IDLE && bus_conv_req_in;
  endsequence
  sequence s_start_issued;
    adc_start_out && state_r == adc_ctrl_pkg::S_CONV;
  endsequence

  property p_bus_start;
    @(posedge mclk_in) disable iff (rst_in) s_bus_start |=> s_start_issued ##0 scl_oe_out;
  endproperty
  a_bus_start: assert property (p_bus_start) else $error("bus start missed");

  property p_stretch_hold;
    @(posedge mclk_in) disable iff (rst_in) scl_oe_out && !done_evt |=> scl_oe_out;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("stretch dropped early");

  property p_no_stretch_reg;
    @(posedge mclk_in) disable iff (rst_in)
      conversion_start_bit_wr && !bus_conv_req_in && state_r == adc_ctrl_pkg::S_IDLE && !scl_oe_out |=> !scl_oe_out [*2];
  endproperty
  a_no_stretch_reg: assert property (p_no_stretch_reg) else $error("register start stretched");

  property p_done_flag;
    @(posedge mclk_in) disable iff (rst_in) done_evt |=> avg_done_r && result_valid_out && !scl_oe_out;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done not flagged");

  property p_bad_byte;
    @(posedge mclk_in) disable iff (rst_in) rx_bad |=> crc_err_r && !rx_valid_out;
  endproperty
  a_bad_byte: assert property (p_bad_byte) else $error("bad byte passed");

  property p_write_block;
    @(posedge mclk_in) disable iff (rst_in) crc_err_r && wr_in && addr_in == `REG_SEQ_SEL |=> $stable(seq_sel_r);
  endproperty
  a_write_block: assert property (p_write_block) else $error("write not blocked");

  property p_alert;
    @(posedge mclk_in) disable iff (rst_in) gen_cfg_r[`GEN_ALERT_CRC] && crc_err_r |=> alert_out;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");

  property p_tx_crc;
    @(posedge mclk_in) disable iff (rst_in)
      tx_valid_in && crc_en |=> tx_crc_valid_out && tx_crc_out == crc8($past(tx_byte_in));
  endproperty
  a_tx_crc: assert property (p_tx_crc) else $error("check byte wrong");

  property p_flags;
    @(posedge mclk_in) disable iff (rst_in)
      done_evt && append_sel == `APPEND_FLAGS |=> result_frame_out[3:1] == {`FLAGS_FIXED, $past(crc_err_r)};
  endproperty
  a_flags: assert property (p_flags) else $error("status flags wrong");

  property p_spacing;
    @(posedge mclk_in) disable iff (rst_in)
      adc_start_out && $past(state_r == adc_ctrl_pkg::S_SPACE) |-> gap_r >= spacing_r - 1'b1;
  endproperty
  a_spacing: assert property (p_spacing) else $error("internal start too early");

endmodule : adc_avg_crc_gpio_timing_ctrl

// file: sim/adc_model.sv
module adc_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  output logic done_out,
  output logic [11:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  logic odd_r;
  // ****************************************
  // converter: fixed latency, alternating codes
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 2'h0;
      odd_r <= 1'b0;
      done_out <= 1'b0;
      data_out <= 12'h000;
    end else begin
      done_out <= 1'b0;
      // between answers the last sample and its inverse alternate each cycle
      data_out <= ~data_out;
      if (start_in) begin
        cnt_r <= 2'h3; // same latency whatever the spacing
      end else if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
        if (cnt_r == 2'h1) begin
          done_out <= 1'b1;
          data_out <= odd_r ? 12'h101 : 12'h100;
          odd_r <= ~odd_r;
        end
      end
    end
  end
endmodule : adc_model

// file: sim/tb_top.sv
`include "adc_ctrl_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, rst_in, wr_in, rd_in, rx_valid_in, tx_valid_in, bus_conv_req_in, scl_in;
  logic rx_valid_out, tx_crc_valid_out, result_valid_out, scl_out_out, scl_oe_out;
  logic adc_start_out, adc_done_in, alert_out;
  logic [7:0] addr_in, rx_byte_in, rx_crc_in, tx_byte_in, gpio_in_in, rx_byte_out, tx_crc_out;
  logic [7:0] gpio_out_out, gpio_oe_out;
  logic [31:0] wdata_in, rdata_out, r;
  logic [19:0] result_frame_out;
  logic [11:0] adc_data_in;
  logic [2:0] adc_ch_out;
  int err_count = 0;
  int cmp_count = 0;

  adc_avg_crc_gpio_timing_ctrl #(.UNIT_CYCLES(1)) DUT (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .rx_valid_in, .rx_byte_in, .rx_crc_in, .rx_valid_out, .rx_byte_out, .tx_valid_in,
    .tx_byte_in, .tx_crc_valid_out, .tx_crc_out, .bus_conv_req_in, .result_valid_out, .result_frame_out,
    .scl_in, .scl_out_out, .scl_oe_out, .adc_start_out, .adc_ch_out, .adc_done_in, .adc_data_in,
    .gpio_in_in, .gpio_out_out, .gpio_oe_out, .alert_out);
  adc_model cnv (.clk_in(mclk_in), .rst_in(rst_in), .start_in(adc_start_out), .done_out(adc_done_in),
    .data_out(adc_data_in));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    r = rdata_out;
  endtask : rd
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = b;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc8
  task automatic rx(input logic [7:0] b, input logic [7:0] c, input logic ok);
    @(posedge mclk_in);
    rx_valid_in <= 1'b1;
    rx_byte_in <= b;
    rx_crc_in <= c;
    @(posedge mclk_in);
    rx_valid_in <= 1'b0;
    @(negedge mclk_in);
    chk(rx_valid_out, ok, "rx forwarded");
    if (ok) chk(rx_byte_out, b, "rx byte");
  endtask : rx
  // polls for the result, checks stretch level and number of samples
  task automatic wait_res(input logic oe, input int starts);
    int n, s;
    n = 0;
    s = 0;
    @(negedge mclk_in);
    while (result_valid_out !== 1'b1) begin
      chk(scl_oe_out, oe, "scl hold");
      if (adc_start_out === 1'b1) s++;
      n++;
      if (n > 400) begin
        err_count++;
        $display("mismatch at %0t: no result", $time);
        final_report();
      end
      @(negedge mclk_in);
    end
    chk(scl_oe_out, 1'b0, "scl freed");
    chk(s, starts, "sample count");
  endtask : wait_res
  // cycles counted from the negedge after the call up to the next start pulse
  task automatic wait_start(output int n);
    n = 0;
    @(negedge mclk_in);
    while (adc_start_out !== 1'b1) begin
      n++;
      if (n > 200) begin
        err_count++;
        $display("mismatch at %0t: no start", $time);
        final_report();
      end
      @(negedge mclk_in);
    end
  endtask : wait_start

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(`REG_THRESH_HIGH);
    chk(r, 32'h0000_0FFF, "thr high");
    rd(8'h80);
    chk(r, 32'h0, "unmapped");
    rd(`REG_PIN_CFG);
    chk(r, 32'h0, "pins analog");
    // two synchroniser stages after the falling pin edge
    @(negedge scl_in);
    repeat (2) @(posedge mclk_in);
    rd(`REG_SYS_STATUS);
    chk(r[3], 1'b0, "scl low seen");
    $display("test reset done");
  endtask : t_reset
  task automatic t_tx;
    logic [7:0] v [3] = '{8'h01, 8'hA5, 8'hFF};
    wr(`REG_GEN_CFG, 32'h1);
    foreach (v[i]) begin
      @(posedge mclk_in);
      tx_valid_in <= 1'b1;
      tx_byte_in <= v[i];
      @(posedge mclk_in);
      tx_valid_in <= 1'b0;
      @(negedge mclk_in);
      chk(tx_crc_valid_out, 1'b1, "tx check");
      chk(tx_crc_out, crc8(v[i]), "tx value");
    end
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx;
    wr(`REG_GEN_CFG, 32'h9);
    rx(8'h3C, crc8(8'h3C), 1'b1);
    rx(8'h5A, crc8(8'h5A) ^ 8'h01, 1'b0);
    @(negedge mclk_in);
    chk(alert_out, 1'b1, "alert");
    rd(`REG_SYS_STATUS);
    chk(r[0], 1'b1, "err flag");
    wr(`REG_SEQ_SEL, 32'hFF);
    rd(`REG_SEQ_SEL);
    chk(r, 32'h0, "write blocked");
    wr(`REG_SYS_STATUS, 32'h1);
    rd(`REG_SYS_STATUS);
    chk(r[0], 1'b0, "err cleared");
    chk(alert_out, 1'b0, "alert off");
    wr(`REG_GEN_CFG, 32'h0);
    $display("test rx done");
  endtask : t_rx
  task automatic t_bus_avg;
    wr(`REG_AVG_CFG, 32'h2);
    wr(`REG_GEN_CFG, 32'h20);
    @(posedge mclk_in);
    bus_conv_req_in <= 1'b1;
    @(posedge mclk_in);
    bus_conv_req_in <= 1'b0;
    wait_res(1'b1, 4);
    chk(result_frame_out, 20'h10088, "frame");
    chk(scl_out_out, 1'b0, "scl low level");
    rd(`REG_SYS_STATUS);
    chk(r[1], 1'b1, "avg done");
    wr(`REG_SYS_STATUS, 32'h2);
    $display("test bus avg done");
  endtask : t_bus_avg
  task automatic t_reg_avg;
    wr(`REG_AVG_CFG, 32'h1);
    wr(`REG_MANUAL_CH, 32'h0);
    wr(`REG_GEN_CFG, 32'h6);
    wait_res(1'b0, 2);
    chk(result_frame_out, 20'h10080, "frame");
    rd(`REG_SYS_STATUS);
    chk(r[1], 1'b1, "avg done");
    rd(`REG_RESULT_BASE);
    chk(r, 32'h08, "low byte");
    rd(8'h44);
    chk(r, 32'h10, "high byte");
    $display("test reg avg done");
  endtask : t_reg_avg
  // autonomous walk over ch2 and ch5, 32 us spacing at one cycle per half us
  task automatic t_auto;
    int n;
    wr(`REG_THRESH_HIGH, 32'h0FF);
    wr(`REG_AVG_CFG, 32'h0);
    wr(`REG_TIMING_CFG, 32'h10);
    wr(`REG_SEQ_SEL, 32'h24);
    wr(`REG_GEN_CFG, 32'hC1);
    for (int k = 0; k < 3; k++) begin
      wait_start(n);
      if (k > 0) chk(n, 64 - 1, "spacing");
      chk(adc_ch_out, (k == 1) ? 3'h5 : 3'h2, "channel");
    end
    rx(8'h11, crc8(8'h11) ^ 8'h01, 1'b0);
    n = 0;
    repeat (100) begin
      @(negedge mclk_in);
      if (adc_start_out === 1'b1) n++;
    end
    chk(n, 0, "halted");
    rd(`REG_EVENT_FLAGS);
    chk(r, 32'h24, "window events");
    rd(`REG_SYS_STATUS);
    chk(r[2], 1'b0, "idle after error");
    wr(`REG_SYS_STATUS, 32'h1);
    wr(`REG_GEN_CFG, 32'h0);
    $display("test auto done");
  endtask : t_auto
  task automatic t_gpio;
    wr(`REG_PIN_CFG, 32'hF0);
    wr(`REG_DIR_CFG, 32'hC0);
    wr(`REG_DRIVE_CFG, 32'h80);
    wr(`REG_OUT_LEVELS, 32'hFF);
    @(negedge mclk_in);
    chk(gpio_oe_out, 8'h80, "oe high level");
    chk(gpio_out_out[7], 1'b1, "push-pull high");
    wr(`REG_OUT_LEVELS, 32'h0);
    @(negedge mclk_in);
    chk(gpio_oe_out, 8'hC0, "oe low level");
    chk(gpio_out_out[7:6], 2'h0, "outputs low");
    rd(`REG_IN_LEVELS);
    chk(r, 32'h20, "input levels");
    $display("test gpio done");
  endtask : t_gpio

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  initial begin
    scl_in = 1'b1;
    forever #80 scl_in = ~scl_in;
  end
  initial begin
    {wr_in, rd_in, rx_valid_in, tx_valid_in, bus_conv_req_in} = 5'h00;
    {addr_in, rx_byte_in, rx_crc_in, tx_byte_in} = 32'h0;
    wdata_in = 32'h0;
    gpio_in_in = 8'hA5;
    rst_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_bus_avg();
    t_reg_avg();
    t_auto();
    t_gpio();
    final_report();
  end
endmodule : tb_top
